/* File: rtl/sbrr_defs.svh */
// Purpose: Constants for the storage bus return routing block.
// Assumes: Included by bare name from the design file.
// Notes:   Bit numbering of addresses follows the machine: bit 0 is the most significant.
`ifndef SBRR_DEFS_SVH
`define SBRR_DEFS_SVH
`define SBRR_POS_A      0
`define SBRR_POS_B      1
`define SBRR_POS_J      2
`define SBRR_POS_CHAN   3
`define SBRR_POS_INV    4
`define SBRR_POS_DIAG   5
`define SBRR_OFF_LIMIT  8'h00
`define SBRR_OFF_STATUS 8'h04
`define SBRR_OFF_ADDR   8'h08
`define SBRR_LIMIT_RST  24'hFFFFFF
`define SBRR_RESP_OK    2'h0
`define SBRR_RESP_ERR   2'h2
`endif

/* File: rtl/sbrr_pkg.sv */
// Purpose: Types shared by the storage bus return routing block.
// Assumes: Nothing.
// Notes:   Operation kinds of a CPU storage request.
package sbrr_pkg;
  typedef enum logic [2:0] {
    SBRR_OP_IFETCH_EVEN,
    SBRR_OP_IFETCH_ODD,
    SBRR_OP_OPERAND,
    SBRR_OP_STORE,
    SBRR_OP_DIAGNOSE
  } sbrr_op_e;
  typedef logic [5:0] sbrr_pos_t;
endpackage : sbrr_pkg

/* File: rtl/sbrr_storage_bus_return_routing.sv */
// Purpose: Storage bus datapath: address register, store and fetch latches, return routing.
// Assumes: Storage units and channels run on aclk; channel-over-CPU priority is decided in this block.
// Notes:   Registers reached over AXI4-Lite with an 8-bit byte address.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sbrr_defs.svh"
module sbrr_storage_bus_return_routing (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              load_from_adder,
  input  wire logic [0:31]       adder_bits,
  input  wire logic [0:2]        adder_parity,
  input  wire logic              load_from_incr,
  input  wire logic [0:23]       incr_bits,
  input  wire logic [0:2]        incr_parity,
  input  wire logic              scan_release,
  input  wire logic              cpu_request,
  input  wire sbrr_pkg::sbrr_op_e cpu_op,
  input  wire logic [3:0]        unit_busy,
  input  wire logic              chan_request,
  input  wire logic              chan_store,
  input  wire logic [0:23]       channel_address_bus,
  input  wire logic [71:0]       chan_store_bus,
  input  wire logic [71:0]       k_reg,
  input  wire logic              storage_advance,
  input  wire logic [287:0]      unit_fetch_bus,
  input  wire logic [71:0]       console_pre_or,
  output logic [0:23]            cpu_storage_address_reg,
  output logic [0:8]             fast_select_address_copy,
  output logic [0:23]            storage_address,
  output logic [3:0]             storage_unit_select,
  output logic                   cpu_accept,
  output logic                   chan_accept,
  output logic [71:0]            store_data_latch,
  output logic [71:0]            fetch_data_latch,
  output logic                   deliver_a,
  output logic                   deliver_b,
  output logic                   deliver_j,
  output logic                   deliver_chan,
  output logic                   deliver_mcw,
  output logic                   invalid_a,
  output logic                   invalid_b,
  output logic                   invalid_j,
  output logic                   chan_invalid_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Internal state.
  logic [0:2]          addr_parity;
  logic [23:0]         storage_limit;
  sbrr_pkg::sbrr_pos_t ret_x;
  sbrr_pkg::sbrr_pos_t ret_y;
  sbrr_pkg::sbrr_pos_t next_pos;
  logic                req_ptr;
  logic                ret_ptr;
  logic                inv_adv_pend;
  logic                store_pend;
  logic                store_from_chan;
  logic                store_inhibit;
  logic [23:0]         next_limit;

  ////////////////////////////////////////////////////////////////////////////
  // Address source selection; scan-in enters through the incrementer path.
  wire [0:23] adder_field = adder_bits[8:31];
  wire [0:23] next_addr   = scan_release    ? incr_bits :
                            load_from_adder ? adder_field :
                            load_from_incr  ? incr_bits : cpu_storage_address_reg;
  wire [0:2]  next_parity = scan_release    ? incr_parity :
                            load_from_adder ? adder_parity :
                            load_from_incr  ? incr_parity : addr_parity;
  wire [0:8]  next_copy   = {next_addr[0:6], next_addr[19:20]};

  // CPU unit choice comes from the fast copy path; the range check uses the full next address.
  wire [1:0] cpu_unit     = next_copy[7:8];
  wire [1:0] chan_unit    = channel_address_bus[19:20];
  wire       cpu_invalid  = next_addr >= storage_limit;
  wire       chan_invalid = channel_address_bus >= storage_limit;
  wire       cpu_is_store = cpu_op == sbrr_pkg::SBRR_OP_STORE;

  // Channel requests take precedence; an invalid request never waits on a busy unit.
  wire       chan_go     = chan_request & (chan_invalid | ~unit_busy[chan_unit]);
  wire       cpu_go      = cpu_request & ~chan_request & (cpu_invalid | ~unit_busy[cpu_unit]);
  wire       sel_fire    = cpu_go | chan_go;
  wire       sel_invalid = chan_go ? chan_invalid : cpu_invalid;
  wire [1:0] sel_unit    = chan_go ? chan_unit : cpu_unit;
  wire       sel_store   = chan_go ? chan_store : cpu_is_store;
  wire [3:0] next_select = (sel_fire & ~sel_invalid) ? 4'(4'h1 << sel_unit) : 4'h0;

  // Routing positions for the request being selected.
  always_comb begin
    next_pos = '0;
    if (chan_go) begin
      next_pos[`SBRR_POS_CHAN] = 1'b1;
      next_pos[`SBRR_POS_INV]  = chan_invalid;
    end else if (cpu_go) begin
      case (cpu_op)
        sbrr_pkg::SBRR_OP_IFETCH_EVEN: next_pos[`SBRR_POS_A] = 1'b1;
        sbrr_pkg::SBRR_OP_IFETCH_ODD:  next_pos[`SBRR_POS_B] = 1'b1;
        sbrr_pkg::SBRR_OP_OPERAND:     next_pos[`SBRR_POS_J] = 1'b1;
        sbrr_pkg::SBRR_OP_DIAGNOSE:    next_pos[`SBRR_POS_DIAG] = 1'b1;
        default:                       next_pos = '0;
      endcase
      if (!cpu_is_store) begin
        next_pos[`SBRR_POS_INV] = cpu_invalid;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address register, its parity and the fast copy load together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_storage_address_reg  <= '0;
      addr_parity              <= '0;
      fast_select_address_copy <= '0;
    end else begin
      cpu_storage_address_reg  <= next_addr;
      addr_parity              <= next_parity;
      fast_select_address_copy <= next_copy;
    end
  end

  // Select is issued at the same edge the address is loaded.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      storage_address     <= '0;
      storage_unit_select <= 4'h0;
      cpu_accept          <= 1'b0;
      chan_accept         <= 1'b0;
    end else begin
      storage_address     <= chan_go ? channel_address_bus : next_addr;
      storage_unit_select <= next_select;
      cpu_accept          <= cpu_go;
      chan_accept         <= chan_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return-address registers written alternately under the request pointer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_x        <= '0;
      ret_y        <= '0;
      req_ptr      <= 1'b0;
      inv_adv_pend <= 1'b0;
    end else begin
      if (sel_fire) begin
        if (req_ptr) begin
          ret_y <= next_pos;
        end else begin
          ret_x <= next_pos;
        end
        req_ptr <= ~req_ptr;
      end
      // Cancelled storage never answers, so the block makes the advance itself.
      // A cancelled CPU store routes nothing but still consumes one advance to keep the pointers paired.
      inv_adv_pend <= sel_fire & sel_invalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advance routing under the return pointer.
  wire                  adv_eff   = storage_advance | inv_adv_pend;
  sbrr_pkg::sbrr_pos_t  route_pos;
  assign route_pos = ret_ptr ? ret_y : ret_x;
  wire                  route_ok  = adv_eff & ~route_pos[`SBRR_POS_INV];
  wire                  route_bad = adv_eff & route_pos[`SBRR_POS_INV];

  // Five-way OR in front of the fetch latch.
  wire [71:0] or_chain [0:4];
  assign or_chain[0] = console_pre_or;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_fetch_or
      assign or_chain[g+1] = or_chain[g] | unit_fetch_bus[g*72 +: 72];
    end
  endgenerate
  wire [71:0] fetch_or = or_chain[4];

  // Pointer toggles on the same edge the current positions are used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_ptr           <= 1'b0;
      fetch_data_latch  <= '0;
      deliver_a         <= 1'b0;
      deliver_b         <= 1'b0;
      deliver_j         <= 1'b0;
      deliver_chan      <= 1'b0;
      deliver_mcw       <= 1'b0;
      invalid_a         <= 1'b0;
      invalid_b         <= 1'b0;
      invalid_j         <= 1'b0;
      chan_invalid_addr <= 1'b0;
    end else begin
      if (adv_eff) begin
        ret_ptr <= ~ret_ptr;
      end
      if (route_ok) begin
        fetch_data_latch <= fetch_or;
      end
      deliver_a         <= route_ok & route_pos[`SBRR_POS_A];
      deliver_b         <= route_ok & route_pos[`SBRR_POS_B];
      deliver_j         <= route_ok & route_pos[`SBRR_POS_J];
      deliver_chan      <= route_ok & route_pos[`SBRR_POS_CHAN];
      deliver_mcw       <= route_ok & route_pos[`SBRR_POS_DIAG];
      invalid_a         <= route_bad & route_pos[`SBRR_POS_A];
      invalid_b         <= route_bad & route_pos[`SBRR_POS_B];
      invalid_j         <= route_bad & route_pos[`SBRR_POS_J];
      chan_invalid_addr <= route_bad & route_pos[`SBRR_POS_CHAN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store latch: released the cycle after a store select, then held one more.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_pend       <= 1'b0;
      store_from_chan  <= 1'b0;
      store_inhibit    <= 1'b0;
      store_data_latch <= '0;
    end else begin
      store_pend      <= sel_fire & ~sel_invalid & sel_store;
      store_from_chan <= chan_go;
      store_inhibit   <= store_pend & ~store_inhibit;
      if (store_pend && !store_inhibit) begin
        store_data_latch <= store_from_chan ? chan_store_bus : k_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register decode.
  wire        wr_limit  = s_axi_awaddr == `SBRR_OFF_LIMIT;
  wire        wr_hit    = wr_limit;
  wire        rd_limit  = s_axi_araddr == `SBRR_OFF_LIMIT;
  wire        rd_status = s_axi_araddr == `SBRR_OFF_STATUS;
  wire        rd_addr   = s_axi_araddr == `SBRR_OFF_ADDR;
  wire        rd_hit    = rd_limit | rd_status | rd_addr;
  wire [31:0] status_w  = {16'h0000, inv_adv_pend, store_inhibit, ret_y, ret_x, ret_ptr, req_ptr};
  wire [31:0] addr_w    = {5'h00, addr_parity, cpu_storage_address_reg};
  wire [31:0] rd_mux    = rd_limit  ? {8'h00, storage_limit} :
                          rd_status ? status_w :
                          rd_addr   ? addr_w : 32'h00000000;
  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        ar_take   = s_axi_arvalid & s_axi_arready;

  // Byte-lane merge of the installed-storage limit.
  always_comb begin
    next_limit = storage_limit;
    for (int i = 0; i < 3; i++) begin
      if (s_axi_wstrb[i]) begin
        next_limit[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
      end
    end
  end

  // Write channel: address and data taken together, then one response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SBRR_RESP_OK;
      storage_limit <= `SBRR_LIMIT_RST;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (aw_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SBRR_RESP_OK : `SBRR_RESP_ERR;
        if (wr_limit) begin
          storage_limit <= next_limit;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SBRR_RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `SBRR_RESP_OK : `SBRR_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks of the routing and latch behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_req_ptr_flip: assert property (sel_fire |=> req_ptr != $past(req_ptr))
    else $error("request pointer did not toggle on select");
  chk_ret_ptr_flip: assert property (adv_eff |=> ret_ptr != $past(ret_ptr))
    else $error("return pointer did not toggle on advance");
  chk_store_no_pos: assert property (cpu_go && cpu_is_store |=>
    ($past(req_ptr) ? ret_y : ret_x) == 6'h00)
    else $error("cpu store left a routing position set");
  chk_even_fetch_pos: assert property (cpu_go && cpu_op == sbrr_pkg::SBRR_OP_IFETCH_EVEN
    |=> ($past(req_ptr) ? ret_y[`SBRR_POS_A] : ret_x[`SBRR_POS_A]))
    else $error("even fetch did not set first buffer position");
  chk_chan_route: assert property (route_ok && route_pos[`SBRR_POS_CHAN] |=> deliver_chan)
    else $error("channel advance not forwarded");
  chk_invalid_cancel: assert property (sel_fire && sel_invalid |=>
    storage_unit_select == 4'h0 ##1 !$stable(ret_ptr))
    else $error("invalid select not cancelled and routed");
  chk_store_hold: assert property ($changed(store_data_latch) |=> $stable(store_data_latch))
    else $error("store latch changed in inhibited cycle");
  chk_adder_load: assert property (load_from_adder && !scan_release |=>
    cpu_storage_address_reg == $past(adder_field))
    else $error("address register did not take adder bits 8-31");
  chk_fetch_or: assert property (route_ok |=> fetch_data_latch == $past(fetch_or))
    else $error("fetch latch does not hold the five-way OR");
  chk_same_cycle_sel: assert property (cpu_go && !cpu_invalid |=>
    cpu_accept && storage_unit_select == 4'(4'h1 << fast_select_address_copy[7:8]))
    else $error("select not issued with the address load");

  // Refusal, source, error and maintenance paths.
  chk_busy_refuse: assert property (cpu_request && !chan_request && !cpu_invalid
    && unit_busy[cpu_unit] |=> !cpu_accept)
    else $error("busy unit took a cpu request");

  chk_chan_addr: assert property (chan_go |=>
    storage_address == $past(channel_address_bus))
    else $error("channel address not sent to storage");

  chk_store_src: assert property (store_pend && !store_inhibit |=>
    store_data_latch == $past(store_from_chan ? chan_store_bus : k_reg))
    else $error("store latch took the wrong source");

  chk_invalid_flag: assert property (route_bad && route_pos[`SBRR_POS_J] |=>
    invalid_j && !deliver_j)
    else $error("invalid operand advance not flagged");

  chk_diag_pos: assert property (cpu_go && cpu_op == sbrr_pkg::SBRR_OP_DIAGNOSE |=>
    ($past(req_ptr) ? ret_y[`SBRR_POS_DIAG] : ret_x[`SBRR_POS_DIAG]))
    else $error("diagnose did not set diagnose position");

  chk_scan_load: assert property (scan_release |=>
    cpu_storage_address_reg == $past(incr_bits))
    else $error("scan-in did not load through incrementer path");

  cov_back_to_back: cover property (sel_fire ##1 sel_fire);
  cov_invalid_route: cover property (route_bad);
  cov_store_inhibit: cover property (store_pend && store_inhibit);
  cov_overlap: cover property (sel_fire ##1 sel_fire ##1 storage_advance ##1 storage_advance);
  cov_diagnose_route: cover property (deliver_mcw);

endmodule : sbrr_storage_bus_return_routing

/* File: tb/sbrr_storage_model.sv */
// Purpose: Storage unit model; answers every select with one advance.
// Assumes: Selects are one-cycle one-hot pulses on aclk.
// Notes:   With no answer due, all unit lines carry a pattern that changes every cycle; in an answer cycle the other units carry zero.
`timescale 1ns/1ps
module sbrr_storage_model (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   sel,
  input  wire logic [3:0]   lat,
  output logic              adv,
  output logic [287:0]      bus,
  output logic [71:0]       word
);
  int          cyc = 0;
  int          due[$];
  int          unt[$];
  int          u;
  logic [71:0] w;
  logic        go;
  // Queue selects in order and answer each once its latency has run out.
  always @(posedge aclk) begin
    cyc = cyc + 1;
    w = {8'(cyc), 32'(~cyc), 32'(cyc * 7)};
    go = 1'b0;
    u = 0;
    if (!aresetn) begin
      due.delete();
      unt.delete();
    end else begin
      if (|sel) begin
        due.push_back(cyc + int'(lat));
        unt.push_back(sel[3] ? 3 : sel[2] ? 2 : sel[1] ? 1 : 0);
      end
      if (due.size() > 0 && due[0] <= cyc) begin
        go = 1'b1;
        void'(due.pop_front());
        u = unt.pop_front();
      end
    end
    adv <= go;
    bus <= go ? 288'(w) << (72 * u) : {4{~w}};
    if (go) word <= w;
  end
endmodule : sbrr_storage_model

/* File: tb/storage_bus_return_routing_tb.sv */
// Purpose: Self-checking bench for the storage bus return routing block.
// Assumes: Storage units are stood in for by sbrr_storage_model.
// Notes:   Each scenario covers one area: reset, address load, fetch routing, overlap, stores and channel, invalid addresses.
`timescale 1ns/1ps
`include "sbrr_defs.svh"
module storage_bus_return_routing_tb;
  logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]         s_axi_wstrb, unit_busy, storage_unit_select, lat;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic               load_from_adder, load_from_incr, scan_release, cpu_request, chan_request, chan_store;
  logic               storage_advance, cpu_accept, chan_accept, deliver_a, deliver_b, deliver_j, deliver_chan;
  logic               deliver_mcw, invalid_a, invalid_b, invalid_j, chan_invalid_addr;
  logic [0:31]        adder_bits;
  logic [0:2]         adder_parity, incr_parity;
  logic [0:23]        incr_bits, channel_address_bus, cpu_storage_address_reg, storage_address;
  logic [0:8]         fast_select_address_copy;
  logic [71:0]        chan_store_bus, k_reg, console_pre_or, store_data_latch, fetch_data_latch, word;
  logic [287:0]       unit_fetch_bus;
  sbrr_pkg::sbrr_op_e cpu_op;
  int                 fail_count = 0, cmp_count = 0, cycles = 0;
  wire  [8:0]         route = {deliver_a, deliver_b, deliver_j, deliver_chan, deliver_mcw,
                               invalid_a, invalid_b, invalid_j, chan_invalid_addr};
  ////////////////////////////////////////////////////////////////////////////////
  sbrr_storage_bus_return_routing dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .load_from_adder, .adder_bits, .adder_parity, .load_from_incr, .incr_bits, .incr_parity, .scan_release,
    .cpu_request, .cpu_op, .unit_busy, .chan_request, .chan_store, .channel_address_bus, .chan_store_bus,
    .k_reg, .storage_advance, .unit_fetch_bus, .console_pre_or, .cpu_storage_address_reg,
    .fast_select_address_copy, .storage_address, .storage_unit_select, .cpu_accept, .chan_accept,
    .store_data_latch, .fetch_data_latch, .deliver_a, .deliver_b, .deliver_j, .deliver_chan, .deliver_mcw,
    .invalid_a, .invalid_b, .invalid_j, .chan_invalid_addr);
  sbrr_storage_model mem_u (.aclk, .aresetn, .sel(storage_unit_select), .lat, .adv(storage_advance),
    .bus(unit_fetch_bus), .word);
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it; mismatches are reported at once.
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  function automatic logic [3:0] usel(input logic [0:23] a);
    return 4'h1 << {a[19], a[20]};
  endfunction : usel
  // Register bus master: holds each channel until its own handshake.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd
  // One-cycle CPU request with an adder load; an idle unit takes it at once.
  task automatic cpu_req(input sbrr_pkg::sbrr_op_e op, input logic [0:23] a, input logic ok);
    @(posedge aclk);
    cpu_request <= 1'b1;
    load_from_adder <= 1'b1;
    adder_bits <= {8'hEE, a};
    k_reg <= {a, a, a};
    cpu_op <= op;
    @(posedge aclk);
    cpu_request <= 1'b0;
    load_from_adder <= 1'b0;
    #1;
    check(cpu_accept, 1'b1);
    check(cpu_storage_address_reg, a);
    check(storage_address, a);
    check(fast_select_address_copy, {a[0:6], a[19:20]});
    check(storage_unit_select, ok ? usel(a) : 4'h0);
  endtask : cpu_req
  task automatic chan_req(input logic st, input logic [0:23] a, input logic ok);
    @(posedge aclk);
    chan_request <= 1'b1;
    chan_store <= st;
    channel_address_bus <= a;
    chan_store_bus <= {3{~a}};
    @(posedge aclk);
    chan_request <= 1'b0;
    #1;
    check(chan_accept, 1'b1);
    if (ok) check(storage_address, a);
    check(storage_unit_select, ok ? usel(a) : 4'h0);
  endtask : chan_req
  // Waits a bounded time for the first routing pulse and compares it.
  task automatic wait_route(input logic [8:0] exp);
    logic [8:0] seen;
    seen = 9'h000;
    for (int n = 0; n < 30 && seen == 9'h000; n++) begin
      @(posedge aclk);
      #1;
      seen = route;
    end
    check(seen, exp);
  endtask : wait_route
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge aclk);
    #1;
    check({route, storage_unit_select, store_data_latch, fetch_data_latch}, 0);
    axi_rd(8'h00, rd, rs);
    check(rd, 32'h00FFFFFF);
    axi_rd(8'h04, rd, rs);
    check(rd, 32'h00000000);
    $display("done: reset");
  endtask : t_reset
  task automatic t_load();
    @(posedge aclk);
    scan_release <= 1'b1;
    load_from_adder <= 1'b1;
    incr_bits <= 24'hABCDE8;
    @(posedge aclk);
    scan_release <= 1'b0;
    load_from_adder <= 1'b0;
    load_from_incr <= 1'b1;
    #1;
    check(cpu_storage_address_reg, 24'hABCDE8);
    @(posedge aclk);
    incr_bits <= 24'h13579B;
    incr_parity <= 3'h5;
    @(posedge aclk);
    load_from_incr <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    check(cpu_storage_address_reg, 24'h13579B);
    axi_rd(8'h08, rd, rs);
    check(rd, 32'h0513579B);
    $display("done: address load");
  endtask : t_load
  task automatic t_fetch();
    sbrr_pkg::sbrr_op_e ops[4] = '{sbrr_pkg::SBRR_OP_IFETCH_EVEN, sbrr_pkg::SBRR_OP_IFETCH_ODD,
                                  sbrr_pkg::SBRR_OP_OPERAND, sbrr_pkg::SBRR_OP_DIAGNOSE};
    logic [8:0] rt[4] = '{9'h100, 9'h080, 9'h040, 9'h010};
    for (int i = 0; i < 4; i++) begin
      cpu_req(ops[i], 24'h012340 | (24'(i) << 3), 1'b1);
      wait_route(rt[i]);
      check(fetch_data_latch, word | console_pre_or);
    end
    $display("done: fetch routing");
  endtask : t_fetch
  task automatic t_overlap();
    @(posedge aclk);
    lat <= 4'h9;
    cpu_req(sbrr_pkg::SBRR_OP_IFETCH_EVEN, 24'h000100, 1'b1);
    cpu_req(sbrr_pkg::SBRR_OP_OPERAND, 24'h000208, 1'b1);
    wait_route(9'h100);
    wait_route(9'h040);
    $display("done: overlap");
  endtask : t_overlap
  task automatic t_store();
    cpu_req(sbrr_pkg::SBRR_OP_STORE, 24'h000410, 1'b1);
    repeat (2) @(posedge aclk);
    #1;
    check(store_data_latch, {3{24'h000410}});
    wait_route(9'h000);
    chan_req(1'b1, 24'h000818, 1'b1);
    repeat (2) @(posedge aclk);
    #1;
    check(store_data_latch, {3{~24'h000818}});
    wait_route(9'h020);
    chan_req(1'b0, 24'h000C00, 1'b1);
    wait_route(9'h020);
    check(fetch_data_latch, word | console_pre_or);
    $display("done: stores and channel");
  endtask : t_store
  task automatic t_invalid();
    logic [8:0] rt[3] = '{9'h008, 9'h004, 9'h002};
    axi_wr(8'h00, 32'h00100000, rs);
    check(rs, `SBRR_RESP_OK);
    unit_busy <= 4'hF;
    for (int i = 0; i < 3; i++) begin
      cpu_req(sbrr_pkg::sbrr_op_e'(i), 24'h100000 | (24'(i) << 3), 1'b0);
      wait_route(rt[i]);
    end
    chan_req(1'b0, 24'h300000, 1'b0);
    wait_route(9'h001);
    axi_rd(8'h0C, rd, rs);
    check({rs, rd}, {`SBRR_RESP_ERR, 32'h0});
    axi_wr(8'h04, 32'h1, rs);
    check(rs, `SBRR_RESP_ERR);
    cpu_request <= 1'b1;
    load_from_adder <= 1'b1;
    adder_bits <= 32'h0;
    @(posedge aclk);
    {cpu_request, load_from_adder, unit_busy} <= '0;
    #1;
    check({cpu_accept, storage_unit_select}, 5'h00);
    $display("done: invalid addresses");
  endtask : t_invalid
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock and the overall hang limit.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // Main sequence: reset, then each scenario in turn.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, load_from_adder} = '0;
    {load_from_incr, scan_release, cpu_request, chan_request, chan_store, unit_busy} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adder_bits, incr_bits, channel_address_bus} = '0;
    {chan_store_bus, k_reg, adder_parity, incr_parity} = '0;
    console_pre_or = 72'h0F;
    s_axi_wstrb = 4'hF;
    lat = 4'h2;
    cpu_op = sbrr_pkg::SBRR_OP_OPERAND;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_load();
    t_fetch();
    t_overlap();
    t_store();
    t_invalid();
    conclude();
  end
endmodule : storage_bus_return_routing_tb
